// ### src/lsp_pkg.sv
// lsp_pkg: shared constants for the lcd shared i/o ports
// assumes a 16-bit byte address space and 8-bit register data
package lsp_pkg;
    // ---------------------------------------------------------
    // register map
    // ---------------------------------------------------------
    localparam int          ADDR_W       = 16;
    localparam int          DATA_W       = 8;
    localparam logic [15:0] ADDR_DATA7   = 16'hffda;
    localparam logic [15:0] ADDR_DATA8   = 16'hffdb;
    localparam logic [15:0] ADDR_DIR7    = 16'hffea;
    localparam logic [15:0] ADDR_DIR8    = 16'hffeb;
    localparam logic [7:0]  RST_DATA7    = 8'h00;
    localparam logic [7:0]  RST_DIR7     = 8'h00;
    localparam logic [7:0]  RST_PORT8    = 8'hfe;
    localparam logic [7:0]  READ_ONES    = 8'hff;
    localparam logic [7:0]  READ_UNMAP   = 8'h00;
    localparam logic [6:0]  PORT8_UPPER  = 7'h7f;
    localparam int          PORT8_BIT    = 0;
    // ---------------------------------------------------------
    // segment-select code ranges, inclusive
    // ---------------------------------------------------------
    localparam logic [3:0]  SEG_HI_LO    = 4'h6;
    localparam logic [3:0]  SEG_HI_HI    = 4'hd;
    localparam logic [3:0]  SEG_LO_LO    = 4'h5;
    localparam logic [3:0]  SEG_LO_HI    = 4'hc;
    localparam logic [3:0]  SEG_P8_LO    = 4'h7;
    localparam logic [3:0]  SEG_P8_HI    = 4'he;
    localparam int          HALF         = 4;
    // ---------------------------------------------------------
    // operating modes from the power controller
    // ---------------------------------------------------------
    typedef enum logic [2:0] {
        LSP_ACTIVE,
        LSP_SUBACTIVE,
        LSP_SLEEP,
        LSP_SUBSLEEP,
        LSP_STANDBY,
        LSP_WATCH
    } lsp_mode_t;
endpackage : lsp_pkg

// ### src/lsp_sync.sv
// lsp_sync: three-stage pin synchroniser with agreement filter
// assumes asynchronous pin levels and one clock domain
`timescale 1ns/10ps
`default_nettype none
module lsp_sync #(
    parameter int W = 8
) (
    input  wire logic         ref_clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] raw,
    output var  logic [W-1:0] level
);
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;

    // ---------------------------------------------------------
    // per-bit chain; level moves once stages two and three agree
    // ---------------------------------------------------------
    for (genvar i = 0; i < W; i++) begin : g_bit
        always_ff @(posedge ref_clk) begin
            if (rst) begin
                s1[i]    <= 1'b0;
                s2[i]    <= 1'b0;
                s3[i]    <= 1'b0;
                level[i] <= 1'b0;
            end else begin
                s1[i] <= raw[i];
                s2[i] <= s1[i];
                s3[i] <= s2[i];
                if (s2[i] == s3[i]) begin
                    level[i] <= s3[i];
                end
            end
        end
    end
endmodule : lsp_sync
`default_nettype wire

// ### src/lsp_ports.sv
// lsp_ports: eight-pin and single-pin gpio ports shared with lcd
// segment outputs, register port, pad control per power mode.
// assumes strobes from a cpu-side master on ref_clk, pins async.
//
// How it works
// - eight-pin data register, read/write, clears to zero on reset
// - data read gives stored bit if direction 1, else live pin
// - eight-pin direction bit 1 means output, 0 input; reset zero
// - eight-pin direction register is write-only, reads all ones
// - data and direction act only on pins left to gpio use
// - segment-select decode per nibble; segment pins drive seg n+17
// - pins hi-z in reset, hold in sleep, hi-z in standby and watch
// - single-pin data in bit 0, bits 7..1 read one, reset 0xfe
// - single-pin direction bit 0, reset 0xfe, write-only, reads ones
// - data registers at 0xffda/0xffdb, direction at 0xffea/0xffeb
// - single pin shared with segment 25 by select code alone; direction has no effect while selected
`timescale 1ns/10ps
`default_nettype none
module lsp_ports (
    input  wire logic              ref_clk,
    input  wire logic              rst,
    input  wire logic [15:0]       addr,
    input  wire logic [7:0]        wr_data,
    input  wire logic              wr_stb,
    input  wire logic              rd_stb,
    output var  logic [7:0]        rd_data,
    input  wire logic [3:0]        segment_select_field,
    input  wire logic [7:0]        lcd_segment_output,
    input  wire logic              lcd_segment_output_25,
    input  wire lsp_pkg::lsp_mode_t power_mode,
    input  wire logic [7:0]        wide_port_pin_in,
    output var  logic [7:0]        wide_port_pin_out,
    output var  logic [7:0]        wide_port_pin_oe_n,
    input  wire logic              single_port_pin_in,
    output var  logic              single_port_pin_out,
    output var  logic              single_port_pin_oe_n
);
    logic [7:0] wide_port_data_reg;
    logic [7:0] wide_port_direction_reg;
    logic       single_pin_data_reg;
    logic       single_pin_direction_reg;
    logic [7:0] wide_level;
    logic [0:0] single_level;
    logic [7:0] wide_seg;
    logic       single_seg;
    logic       seg_hi;
    logic       seg_lo;
    logic       functional;
    logic       hold;
    logic [7:0] next_rd_data;
    logic [7:0] wide_read;
    logic [7:0] single_read;

    // ---------------------------------------------------------
    // pin input synchronisers
    // ---------------------------------------------------------
    lsp_sync #(.W(8)) u_sync_wide (
        .ref_clk (ref_clk),
        .rst     (rst),
        .raw     (wide_port_pin_in),
        .level   (wide_level)
    );

    lsp_sync #(.W(1)) u_sync_single (
        .ref_clk (ref_clk),
        .rst     (rst),
        .raw     (single_port_pin_in),
        .level   (single_level)
    );

    // ---------------------------------------------------------
    // register writes
    // ---------------------------------------------------------
    // eight-pin data register
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wide_port_data_reg <= lsp_pkg::RST_DATA7;
        end else if (wr_stb && addr == lsp_pkg::ADDR_DATA7) begin
            wide_port_data_reg <= wr_data;
        end
    end

    // eight-pin direction register
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wide_port_direction_reg <= lsp_pkg::RST_DIR7;
        end else if (wr_stb && addr == lsp_pkg::ADDR_DIR7) begin
            wide_port_direction_reg <= wr_data;
        end
    end

    // single-pin data and direction, bit 0 only
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            single_pin_data_reg <= lsp_pkg::RST_PORT8[lsp_pkg::PORT8_BIT];
            single_pin_direction_reg <=
                lsp_pkg::RST_PORT8[lsp_pkg::PORT8_BIT];
        end else if (wr_stb) begin
            if (addr == lsp_pkg::ADDR_DATA8) begin
                single_pin_data_reg <= wr_data[lsp_pkg::PORT8_BIT];
            end
            if (addr == lsp_pkg::ADDR_DIR8) begin
                single_pin_direction_reg <=
                    wr_data[lsp_pkg::PORT8_BIT];
            end
        end
    end

    // ---------------------------------------------------------
    // register reads
    // ---------------------------------------------------------
    // per-bit choice of stored data or live pin
    always_comb begin
        wide_read = (wide_port_direction_reg & wide_port_data_reg)
                  | (~wide_port_direction_reg & wide_level);
        single_read = {lsp_pkg::PORT8_UPPER,
                       single_pin_direction_reg ? single_pin_data_reg
                                                : single_level[0]};
    end

    // address decode for reads
    always_comb begin
        case (addr)
            lsp_pkg::ADDR_DATA7: next_rd_data = wide_read;
            lsp_pkg::ADDR_DATA8: next_rd_data = single_read;
            lsp_pkg::ADDR_DIR7:  next_rd_data = lsp_pkg::READ_ONES;
            lsp_pkg::ADDR_DIR8:  next_rd_data = lsp_pkg::READ_ONES;
            default:             next_rd_data = lsp_pkg::READ_UNMAP;
        endcase
    end

    // read data valid the cycle after the strobe, zero otherwise
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rd_data <= lsp_pkg::READ_UNMAP;
        end else if (rd_stb) begin
            rd_data <= next_rd_data;
        end else begin
            rd_data <= lsp_pkg::READ_UNMAP;
        end
    end

    // ---------------------------------------------------------
    // segment-select decode
    // ---------------------------------------------------------
    // each nibble and the single pin have their own code range
    always_comb begin
        seg_hi = segment_select_field >= lsp_pkg::SEG_HI_LO
              && segment_select_field <= lsp_pkg::SEG_HI_HI;
        seg_lo = segment_select_field >= lsp_pkg::SEG_LO_LO
              && segment_select_field <= lsp_pkg::SEG_LO_HI;
        single_seg = segment_select_field >= lsp_pkg::SEG_P8_LO
                  && segment_select_field <= lsp_pkg::SEG_P8_HI;
        wide_seg = {{lsp_pkg::HALF{seg_hi}}, {lsp_pkg::HALF{seg_lo}}};
        functional = power_mode == lsp_pkg::LSP_ACTIVE
                  || power_mode == lsp_pkg::LSP_SUBACTIVE;
        hold = power_mode == lsp_pkg::LSP_SLEEP
            || power_mode == lsp_pkg::LSP_SUBSLEEP;
    end

    // ---------------------------------------------------------
    // pad drive per pin and per power mode
    // ---------------------------------------------------------
    // eight-pin pads; enable is low while driving
    for (genvar i = 0; i < 8; i++) begin : g_wide_pad
        always_ff @(posedge ref_clk) begin
            if (rst) begin
                wide_port_pin_oe_n[i] <= 1'b1;
                wide_port_pin_out[i]  <= 1'b0;
            end else if (hold) begin
                wide_port_pin_oe_n[i] <= wide_port_pin_oe_n[i];
                wide_port_pin_out[i]  <= wide_port_pin_out[i];
            end else if (!functional) begin
                wide_port_pin_oe_n[i] <= 1'b1;
                wide_port_pin_out[i]  <= 1'b0;
            end else if (wide_seg[i]) begin
                wide_port_pin_oe_n[i] <= 1'b0;
                wide_port_pin_out[i]  <= lcd_segment_output[i];
            end else begin
                wide_port_pin_oe_n[i] <= ~wide_port_direction_reg[i];
                wide_port_pin_out[i]  <= wide_port_data_reg[i];
            end
        end
    end

    // single-pin pad, shared with segment 25
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            single_port_pin_oe_n <= 1'b1;
            single_port_pin_out  <= 1'b0;
        end else if (hold) begin
            single_port_pin_oe_n <= single_port_pin_oe_n;
            single_port_pin_out  <= single_port_pin_out;
        end else if (!functional) begin
            single_port_pin_oe_n <= 1'b1;
            single_port_pin_out  <= 1'b0;
        end else if (single_seg) begin
            single_port_pin_oe_n <= 1'b0;
            single_port_pin_out  <= lcd_segment_output_25;
        end else begin
            single_port_pin_oe_n <= ~single_pin_direction_reg;
            single_port_pin_out  <= single_pin_data_reg;
        end
    end

    // ---------------------------------------------------------
    // assertions
    // ---------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    a_data_reset_zero: assert property (
        disable iff (1'b0) rst |=> wide_port_data_reg == 8'h00)
        else $error("wide data not cleared by reset");

    a_data_write_store: assert property (
        wr_stb && addr == 16'hffda |=> wide_port_data_reg == $past(wr_data))
        else $error("wide data write not stored");

    a_read_pin_mux: assert property (
        rd_stb && addr == 16'hffda |=> rd_data ==
        (($past(wide_port_direction_reg) & $past(wide_port_data_reg))
        | (~$past(wide_port_direction_reg) & $past(wide_level))))
        else $error("wide data read mux wrong");

    a_dir_reads_ones: assert property (
        rd_stb && (addr == 16'hffea || addr == 16'hffeb)
        |=> rd_data == 8'hff)
        else $error("direction read not all ones");

    a_single_upper_ones: assert property (
        rd_stb && addr == 16'hffdb |=> rd_data[7:1] == 7'h7f)
        else $error("single data upper bits not ones");

    a_read_one_cycle: assert property (
        !rd_stb |=> rd_data == 8'h00)
        else $error("read data outside its cycle");

    a_gpio_follows_dir: assert property (
        functional && !seg_hi ##1 1'b1 |-> wide_port_pin_oe_n[7:4]
        == ~$past(wide_port_direction_reg[7:4]))
        else $error("gpio pin ignores direction");

    a_seg_drives_pin: assert property (
        functional && seg_lo |=> wide_port_pin_oe_n[3:0] == 4'h0
        && wide_port_pin_out[3:0] == $past(lcd_segment_output[3:0]))
        else $error("segment pin not driven");

    a_single_seg_pin: assert property (
        functional && single_seg |=> !single_port_pin_oe_n
        && single_port_pin_out == $past(lcd_segment_output_25))
        else $error("segment 25 not driven");

    a_standby_hiz: assert property (
        power_mode == lsp_pkg::LSP_STANDBY
        || power_mode == lsp_pkg::LSP_WATCH
        |=> wide_port_pin_oe_n == 8'hff && single_port_pin_oe_n)
        else $error("pins driven in standby or watch");

    a_sleep_holds: assert property (
        hold |=> $stable(wide_port_pin_oe_n) && $stable(wide_port_pin_out))
        else $error("pins changed in sleep");

    a_reset_hiz: assert property (
        disable iff (1'b0) rst |=> wide_port_pin_oe_n == 8'hff
        && single_port_pin_oe_n)
        else $error("pins driven during reset");

    a_reset_out_low: assert property (
        disable iff (1'b0) rst |=> wide_port_pin_out == '0
        && !single_port_pin_out)
        else $error("pin values not low after reset");

    a_single_sleep_holds: assert property (
        hold |=> $stable(single_port_pin_oe_n)
        && $stable(single_port_pin_out))
        else $error("single pin changed in sleep");

    a_dir_reset_zero: assert property (
        disable iff (1'b0) rst |=> wide_port_direction_reg == '0)
        else $error("wide direction not cleared by reset");

    a_dir_write_store: assert property (
        wr_stb && addr == lsp_pkg::ADDR_DIR7
        |=> wide_port_direction_reg == $past(wr_data))
        else $error("wide direction write not stored");

    a_wide_data_decode: assert property (
        !(wr_stb && addr == lsp_pkg::ADDR_DATA7)
        |=> $stable(wide_port_data_reg))
        else $error("wide data changed without its write");

    a_single_data_reset: assert property (
        disable iff (1'b0) rst |=> !single_pin_data_reg)
        else $error("single data not cleared by reset");

    a_single_dir_reset: assert property (
        disable iff (1'b0) rst |=> !single_pin_direction_reg)
        else $error("single direction not cleared by reset");

    a_single_data_write: assert property (
        wr_stb && addr == lsp_pkg::ADDR_DATA8
        |=> single_pin_data_reg == $past(wr_data[lsp_pkg::PORT8_BIT]))
        else $error("single data write not stored");

    a_single_read_mux: assert property (
        rd_stb && addr == lsp_pkg::ADDR_DATA8 |=> rd_data[0] ==
        ($past(single_pin_direction_reg) ? $past(single_pin_data_reg)
                                         : $past(single_level[0])))
        else $error("single data read mux wrong");

    a_unmapped_read: assert property (
        rd_stb && addr != lsp_pkg::ADDR_DATA7 && addr != lsp_pkg::ADDR_DATA8
        && addr != lsp_pkg::ADDR_DIR7 && addr != lsp_pkg::ADDR_DIR8
        |=> rd_data == lsp_pkg::READ_UNMAP)
        else $error("unmapped read not zero");

    a_gpio_low_nibble: assert property (
        functional && !seg_lo |=> wide_port_pin_oe_n[3:0]
        == ~$past(wide_port_direction_reg[3:0])
        && wide_port_pin_out[3:0] == $past(wide_port_data_reg[3:0]))
        else $error("gpio pin ignores direction or data");

    a_seg_hi_drives: assert property (
        functional && seg_hi |=> wide_port_pin_oe_n[7:4] == 4'h0
        && wide_port_pin_out[7:4] == $past(lcd_segment_output[7:4]))
        else $error("upper segment pins not driven");

    a_single_gpio_pin: assert property (
        functional && !single_seg |=> single_port_pin_oe_n
        == ~$past(single_pin_direction_reg)
        && single_port_pin_out == $past(single_pin_data_reg))
        else $error("single pin ignores direction or data");

    c_dir_write_read: cover property (
        wr_stb && addr == 16'hffea ##1 rd_stb && addr == 16'hffda);
    c_seg_mode: cover property (functional && seg_hi && seg_lo);
    c_sleep_then_active: cover property (hold ##1 functional);
    c_single_seg_hi: cover property (functional && single_seg && seg_hi);
    c_single_output: cover property (
        functional && !single_seg && single_pin_direction_reg);
endmodule : lsp_ports
`default_nettype wire

// ### tb/lsp_pad_model.sv
// lsp_pad_model: external pads and lcd segment driver beside lsp_ports
// assumes no contention: the far side drives only a released pad
`timescale 1ns/10ps
`default_nettype none
module lsp_pad_model #(
    parameter logic [7:0] SEG_LVL = 8'h96,
    parameter logic       SEG25   = 1'b1
) (
    input  wire logic [7:0] ext_level,
    input  wire logic       ext_level_8,
    input  wire logic [7:0] wide_port_pin_out,
    input  wire logic [7:0] wide_port_pin_oe_n,
    input  wire logic       single_port_pin_out,
    input  wire logic       single_port_pin_oe_n,
    output wire logic [7:0] wide_port_pin_in,
    output wire logic       single_port_pin_in,
    output wire logic [7:0] lcd_segment_output,
    output wire logic       lcd_segment_output_25
);
    // segment levels from the lcd driver, fixed pattern
    assign lcd_segment_output    = SEG_LVL;
    assign lcd_segment_output_25 = SEG25;
    // pad level: our driver when enabled (oe_n low), else far side
    assign wide_port_pin_in = (wide_port_pin_oe_n & ext_level)
                            | (~wide_port_pin_oe_n & wide_port_pin_out);
    assign single_port_pin_in = single_port_pin_oe_n ? ext_level_8
                                                     : single_port_pin_out;
endmodule : lsp_pad_model
`default_nettype wire

// ### tb/lsp_ports_tb.sv
// lsp_ports_tb: register, pad, segment and power-mode tests
// assumes lsp_pad_model closes the pads; ref_clk at 125 MHz
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin fails++; \
    $display("BAD %0t got %h exp %h", $time, (g), (e)); end end
module lsp_ports_tb;
    localparam logic [7:0] SEG_LVL = 8'h96;
    localparam logic       SEG25   = 1'b1;
    localparam logic [7:0] DIR     = 8'h0f;
    localparam logic [7:0] DAT     = 8'h3c;
    logic               ref_clk = 1'b0;
    logic               rst     = 1'b1;
    logic [15:0]        addr    = 16'h0000;
    logic [7:0]         wr_data = 8'h00;
    logic               wr_stb  = 1'b0;
    logic               rd_stb  = 1'b0;
    logic [3:0]         sel     = 4'h0;
    lsp_pkg::lsp_mode_t mode    = lsp_pkg::LSP_ACTIVE;
    logic [7:0]         ext     = 8'ha5;
    logic               ext8    = 1'b1;
    logic [7:0]         rd_data, lvl, pin_in, pin_out, pin_oe_n, eo, ev;
    logic               lvl25, s_in, s_out, s_oe_n, sg;
    int                 fails = 0;
    int                 check_count = 0;

    // clock
    always #4 ref_clk = ~ref_clk;

    lsp_ports i_lsp_ports (.ref_clk(ref_clk), .rst(rst), .addr(addr),
        .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb),
        .rd_data(rd_data), .segment_select_field(sel),
        .lcd_segment_output(lvl), .lcd_segment_output_25(lvl25),
        .power_mode(mode), .wide_port_pin_in(pin_in),
        .wide_port_pin_out(pin_out), .wide_port_pin_oe_n(pin_oe_n),
        .single_port_pin_in(s_in), .single_port_pin_out(s_out),
        .single_port_pin_oe_n(s_oe_n));
    lsp_pad_model #(.SEG_LVL(SEG_LVL), .SEG25(SEG25)) i_lsp_pad_model (
        .ext_level(ext), .ext_level_8(ext8), .wide_port_pin_out(pin_out),
        .wide_port_pin_oe_n(pin_oe_n), .single_port_pin_out(s_out),
        .single_port_pin_oe_n(s_oe_n), .wide_port_pin_in(pin_in),
        .single_port_pin_in(s_in), .lcd_segment_output(lvl),
        .lcd_segment_output_25(lvl25));

    // -------------------------------------------------------------
    // bus tasks and checks
    // -------------------------------------------------------------
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        addr    <= a;
        wr_data <= d;
        wr_stb  <= 1'b1;
        @(posedge ref_clk);
        wr_stb  <= 1'b0;
    endtask : wr

    task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
        @(posedge ref_clk);
        addr   <= a;
        rd_stb <= 1'b1;
        @(posedge ref_clk);
        rd_stb <= 1'b0;
        #1;
        `CHK(rd_data, e)
    endtask : rd_chk

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : wait_cyc

    task automatic pads(input logic [7:0] oe, input logic [7:0] o);
        wait_cyc(3);
        `CHK(pin_oe_n, oe)
        `CHK(pin_out, o)
    endtask : pads

    task automatic close_out();
        $display("checks %0d fails %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : close_out

    // -------------------------------------------------------------
    // main sequence
    // -------------------------------------------------------------
    initial begin
        wait_cyc(3);
        `CHK(pin_oe_n, 8'hff)
        `CHK(s_oe_n, 1'b1)
        `CHK(rd_data, 8'h00)
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        // let the pin levels pass the synchronisers first
        wait_cyc(5);
        rd_chk(16'hffda, 8'ha5);
        rd_chk(16'hffdb, 8'hff);
        rd_chk(16'hffea, 8'hff);
        rd_chk(16'hffeb, 8'hff);
        wr(16'hffea, 8'hff);
        rd_chk(16'hffda, 8'h00);
        wr(16'hffda, DAT);
        rd_chk(16'hffda, DAT);
        pads(8'h00, DAT);
        rd_chk(16'hffea, 8'hff);
        wr(16'hffea, DIR);
        wait_cyc(6);
        rd_chk(16'hffda, 8'hac);
        pads(8'hf0, DAT);
        wr(16'hffeb, 8'h01);
        wr(16'hffdb, 8'h00);
        rd_chk(16'hffdb, 8'hfe);
        rd_chk(16'hffeb, 8'hff);
        `CHK(s_oe_n, 1'b0)
        rd_chk(16'hffdc, 8'h00);
        wr(16'hffca, 8'h55);
        rd_chk(16'hffda, 8'hac);
        // every select code against the per-group ranges
        for (int c = 0; c < 16; c++) begin
            @(posedge ref_clk);
            sel <= 4'(c);
            wait_cyc(3);
            for (int i = 0; i < 8; i++) begin
                sg = (i < 4) ? (c >= 5 && c <= 12) : (c >= 6 && c <= 13);
                eo[i] = sg ? 1'b0 : ~DIR[i];
                ev[i] = sg ? SEG_LVL[i] : DAT[i];
            end
            `CHK(pin_oe_n, eo)
            `CHK(pin_out, ev)
            `CHK(s_out, (c >= 7 && c <= 14) ? SEG25 : 1'b0)
            `CHK(s_oe_n, 1'b0)
        end
        @(posedge ref_clk);
        sel <= 4'h0;
        pads(8'hf0, DAT);
        // power modes: hold, release, resume
        @(posedge ref_clk);
        mode <= lsp_pkg::LSP_SLEEP;
        wr(16'hffda, 8'hc3);
        pads(8'hf0, DAT);
        `CHK(s_oe_n, 1'b0)
        @(posedge ref_clk);
        mode <= lsp_pkg::LSP_SUBSLEEP;
        pads(8'hf0, DAT);
        @(posedge ref_clk);
        mode <= lsp_pkg::LSP_STANDBY;
        pads(8'hff, 8'h00);
        `CHK(s_oe_n, 1'b1)
        @(posedge ref_clk);
        mode <= lsp_pkg::LSP_WATCH;
        pads(8'hff, 8'h00);
        @(posedge ref_clk);
        mode <= lsp_pkg::LSP_SUBACTIVE;
        pads(8'hf0, 8'hc3);
        `CHK(s_oe_n, 1'b0)
        // reset in mid-run
        @(posedge ref_clk);
        rst <= 1'b1;
        wait_cyc(2);
        `CHK(pin_oe_n, 8'hff)
        `CHK(pin_out, 8'h00)
        `CHK(s_oe_n, 1'b1)
        @(posedge ref_clk);
        rst <= 1'b0;
        wr(16'hffea, 8'hff);
        pads(8'h00, 8'h00);
        rd_chk(16'hffda, 8'h00);
        wr(16'hffeb, 8'h01);
        rd_chk(16'hffdb, 8'hfe);
        close_out();
    end

    // watchdog against a hung run
    initial begin
        repeat (5000) @(posedge ref_clk);
        fails++;
        close_out();
    end
endmodule : lsp_ports_tb
`default_nettype wire
